// [rtl/sio_uart.sv]
`timescale 1ns/1ps
// Functional notes
// - msbFirst selects bit order on line
// - channel one clock on selected pin, internal
// - continuous receive: buffer read re-arms receiver
// - channel two data inversion on write/read
// - inversion touches character bits only
// - channel two pin polarity inverts whole line
// - start, 7/8/9 bits, parity, 1/2 stops
// - internal rate is prescaled/(16(n+1))
// - external rate (channels zero and one) is pin clock/(16(n+1))
// - flow control: CTS, RTS or none
// - send needs enable, data, CTS low
// - receive needs enable and start bit
// - transmit irq at load or completion
// - receive irq when buffer loaded
// - overrun overwrites buffer, no receive irq
// - missing stop bit flags framing error
// - parity mismatch flags parity error
// - error summary on any error
// - sleep (channels zero and one) accepts only characters with MSB set
// - idle line high, or floating open-drain
module sio_uart import sio_pkg::*; #(
   parameter int CHAN  = 0,
   parameter int DIV_W = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             txEnable,
   input  wire logic             rxEnable,
   input  wire logic             msbFirst,
   input  wire logic [1:0]       charLen,
   input  wire logic             parityEn,
   input  wire logic             parityOdd,
   input  wire logic             twoStop,
   input  wire logic [1:0]       clkSrcSel,
   input  wire logic             extClkSel,
   input  wire logic [DIV_W-1:0] brgDivisor,
   input  wire logic [1:0]       flowSel,
   input  wire logic             txIrqCause,
   input  wire logic             contRecv,
   input  wire logic [1:0]       clkPinSel,
   input  wire logic             dataInvert,
   input  wire logic             pinInvert,
   input  wire logic             sleepSel,
   input  wire logic             openDrain,
   input  wire logic             errClear,
   input  wire logic [8:0]       txData,
   input  wire logic             txValid,
   output logic                  txReady,
   output logic                  txEmpty,
   output logic [8:0]            rxData,
   output logic                  rxFull,
   input  wire logic             rxRead,
   output logic                  txIrq,
   output logic                  rxIrq,
   output logic                  overrunErr,
   output logic                  framingErr,
   output logic                  parityErr,
   output logic                  errorSum,
   input  wire logic             serialInPin,
   output logic                  serialOutPin,
   output logic                  serialOutEn,
   input  wire logic             ctsIn,
   output logic                  rtsOut,
   input  wire logic             channelClockIn,
   output logic                  channelClockOut,
   output logic                  channelClockEn,
   output logic                  altClockOut,
   output logic                  altClockEn
);
   generate
      if (CHAN < 0 || CHAN > 2) begin : g_chk
         $error("sio_uart: CHAN must be 0, 1 or 2");
      end
   endgenerate

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sio_txst_t  txSt_q;
   sio_rxst_t  rxSt_q;
   logic [3:0] txPh_q, txBit_q, rxPh_q, rxBit_q, clkDiv_q;
   logic [8:0] txShift_q, rxShift_q, fifoIn, fifoData;
   logic       txPar_q, txStop2_q, txLine_q, rxStop2_q, rxFrame_q, rxPar_q;
   logic       rxArmed_q, fifoValid, fifoInReady, tick16, txGo, txLoad, txDone;
   logic       rxIn, rxEnd, rxLoad, rxStart, rxNewPar, rxFrameNow;
   logic       extEff, pinInv, logicInv, sleepEff;
   logic [3:0] len, lastBit;
   logic [8:0] mask, invMask;

   // picks the shift-register slot of the b-th bit on the line
   function automatic logic [3:0] bitIdx(input logic [3:0] b, input logic [3:0] l, input logic m);
      bitIdx = m ? l - 4'h1 - b : b;
   endfunction

   // channel feature gating
   assign extEff   = extClkSel && (CHAN != SIO_CH_LOGIC);
   assign pinInv   = pinInvert && (CHAN == SIO_CH_LOGIC);
   assign logicInv = dataInvert && (CHAN == SIO_CH_LOGIC);
   assign sleepEff = sleepSel && (CHAN != SIO_CH_LOGIC);
   assign len      = SIO_BASE_LEN + {2'h0, charLen};
   assign lastBit  = len - 4'h1;
   assign mask     = SIO_FULL_MASK >> (SIO_CHAR_W - len);
   assign invMask  = logicInv ? mask : 9'h000;
   assign fifoIn   = txData ^ invMask;
   assign rxIn     = serialInPin ^ pinInv;

   sio_brg #(.DIV_W(DIV_W)) u_brg (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .srcSel   (clkSrcSel),
      .extSel   (extEff),
      .extClkIn (channelClockIn),
      .divisor  (brgDivisor),
      .tick16   (tick16)
   );

   // two words of slack between the cpu and the shifter
   sio_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_txbuf (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .inData   (fifoIn),
      .inValid  (txValid),
      .inReady  (fifoInReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (txLoad)
   );

   // start condition and transmit events
   assign txGo   = txEnable && fifoValid && (flowSel != SIO_FLOW_CTS || !ctsIn);
   assign txLoad = (txSt_q == SIO_TX_IDLE) && txGo;
   assign txDone = (txSt_q == SIO_TX_STOP) && tick16 && txPh_q == SIO_PH_END && !txStop2_q;

   // transmit shifter; every cell lasts sixteen ticks
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         txSt_q    <= SIO_TX_IDLE;
         txPh_q    <= 4'h0;
         txBit_q   <= 4'h0;
         txShift_q <= 9'h000;
         txPar_q   <= 1'b0;
         txStop2_q <= 1'b0;
         txLine_q  <= SIO_LINE_IDLE;
      end else begin
         case (txSt_q)
            SIO_TX_IDLE: begin
               if (txLoad) begin
                  txSt_q    <= SIO_TX_START;
                  txPh_q    <= 4'h0;
                  txBit_q   <= 4'h0;
                  txShift_q <= fifoData;
                  txPar_q   <= ^(fifoData & mask) ^ parityOdd;
                  txLine_q  <= 1'b0;
               end
            end
            SIO_TX_START: begin
               if (tick16) begin
                  txPh_q <= txPh_q + 4'h1;
                  if (txPh_q == SIO_PH_END) begin
                     txSt_q   <= SIO_TX_DATA;
                     txLine_q <= txShift_q[bitIdx(4'h0, len, msbFirst)];
                  end
               end
            end
            SIO_TX_DATA: begin
               if (tick16) begin
                  txPh_q <= txPh_q + 4'h1;
                  if (txPh_q == SIO_PH_END) begin
                     if (txBit_q == lastBit) begin
                        txSt_q    <= parityEn ? SIO_TX_PAR : SIO_TX_STOP;
                        txLine_q  <= parityEn ? txPar_q : 1'b1;
                        txStop2_q <= twoStop;
                     end else begin
                        txBit_q  <= txBit_q + 4'h1;
                        txLine_q <= txShift_q[bitIdx(txBit_q + 4'h1, len, msbFirst)];
                     end
                  end
               end
            end
            SIO_TX_PAR: begin
               if (tick16) begin
                  txPh_q <= txPh_q + 4'h1;
                  if (txPh_q == SIO_PH_END) begin
                     txSt_q   <= SIO_TX_STOP;
                     txLine_q <= 1'b1;
                  end
               end
            end
            SIO_TX_STOP: begin
               if (tick16) begin
                  txPh_q <= txPh_q + 4'h1;
                  if (txPh_q == SIO_PH_END) begin
                     if (txStop2_q) begin
                        txStop2_q <= 1'b0;
                     end else begin
                        txSt_q <= SIO_TX_IDLE;
                     end
                  end
               end
            end
            default: txSt_q <= SIO_TX_IDLE;
         endcase
      end
   end

   // pin stage: open drain only pulls low, floats for a high level
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         serialOutPin <= SIO_LINE_IDLE;
         serialOutEn  <= 1'b0;
         txEmpty      <= 1'b1;
         txReady      <= 1'b0;
         txIrq        <= 1'b0;
      end else begin
         serialOutPin <= txLine_q ^ pinInv;
         serialOutEn  <= !openDrain || !(txLine_q ^ pinInv);
         txEmpty      <= !fifoValid;
         txReady      <= fifoInReady;
         txIrq        <= txIrqCause ? txDone : txLoad;
      end
   end

   // receiver events; the last stop sample is still on rxIn in the rxEnd cycle
   assign rxStart  = (rxSt_q == SIO_RX_IDLE) && tick16 && rxEnable && rxArmed_q && !rxIn;
   assign rxEnd    = (rxSt_q == SIO_RX_STOP) && tick16 && rxPh_q == SIO_PH_END && !rxStop2_q;
   assign rxLoad   = rxEnd && !(sleepEff && !rxShift_q[lastBit]);
   assign rxNewPar = (^(rxShift_q & mask) ^ rxIn) != parityOdd;
   assign rxFrameNow = rxFrame_q || !rxIn;

   // receive shifter; a phase of seven checks the start, fifteen centres later bits
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxSt_q    <= SIO_RX_IDLE;
         rxPh_q    <= 4'h0;
         rxBit_q   <= 4'h0;
         rxShift_q <= 9'h000;
         rxStop2_q <= 1'b0;
         rxFrame_q <= 1'b0;
         rxPar_q   <= 1'b0;
      end else begin
         case (rxSt_q)
            SIO_RX_IDLE: begin
               if (rxStart) begin
                  rxSt_q    <= SIO_RX_START;
                  rxPh_q    <= 4'h0;
                  rxBit_q   <= 4'h0;
                  rxShift_q <= 9'h000;
                  rxFrame_q <= 1'b0;
                  rxPar_q   <= 1'b0;
               end
            end
            SIO_RX_START: begin
               if (tick16) begin
                  rxPh_q <= rxPh_q + 4'h1;
                  if (rxPh_q == SIO_PH_MID) begin
                     rxPh_q <= 4'h0;
                     rxSt_q <= rxIn ? SIO_RX_IDLE : SIO_RX_DATA;
                  end
               end
            end
            SIO_RX_DATA: begin
               if (tick16) begin
                  rxPh_q <= rxPh_q + 4'h1;
                  if (rxPh_q == SIO_PH_END) begin
                     rxShift_q[bitIdx(rxBit_q, len, msbFirst)] <= rxIn;
                     rxBit_q <= rxBit_q + 4'h1;
                     if (rxBit_q == lastBit) begin
                        rxSt_q    <= parityEn ? SIO_RX_PAR : SIO_RX_STOP;
                        rxStop2_q <= twoStop;
                     end
                  end
               end
            end
            SIO_RX_PAR: begin
               if (tick16) begin
                  rxPh_q <= rxPh_q + 4'h1;
                  if (rxPh_q == SIO_PH_END) begin
                     rxPar_q <= rxNewPar;
                     rxSt_q  <= SIO_RX_STOP;
                  end
               end
            end
            SIO_RX_STOP: begin
               if (tick16) begin
                  rxPh_q <= rxPh_q + 4'h1;
                  if (rxPh_q == SIO_PH_END) begin
                     if (!rxIn) begin
                        rxFrame_q <= 1'b1;
                     end
                     if (rxStop2_q) begin
                        rxStop2_q <= 1'b0;
                     end else begin
                        rxSt_q <= SIO_RX_IDLE;
                     end
                  end
               end
            end
            default: rxSt_q <= SIO_RX_IDLE;
         endcase
      end
   end

   // receive buffer; a read in the loading cycle counts as done first
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxData <= 9'h000;
         rxFull <= 1'b0;
         rxIrq  <= 1'b0;
      end else begin
         rxIrq <= rxLoad && !(rxFull && !rxRead);
         if (rxLoad) begin
            rxData <= rxShift_q ^ invMask;
            rxFull <= 1'b1;
         end else if (rxRead) begin
            rxFull <= 1'b0;
         end
      end
   end

   // after a character the receiver waits to be re-armed
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxArmed_q <= SIO_ARM_RST;
      end else if ((rxRead && contRecv) || (txValid && fifoInReady)) begin
         rxArmed_q <= 1'b1;
      end else if (rxLoad) begin
         rxArmed_q <= 1'b0;
      end
   end

   // sticky errors; a new error wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         overrunErr <= 1'b0;
         framingErr <= 1'b0;
         parityErr  <= 1'b0;
         errorSum   <= 1'b0;
      end else begin
         overrunErr <= (rxLoad && rxFull && !rxRead) || (overrunErr && !errClear);
         framingErr <= (rxLoad && rxFrameNow) || (framingErr && !errClear);
         parityErr  <= (rxLoad && rxPar_q) || (parityErr && !errClear);
         errorSum   <= (rxLoad && ((rxFull && !rxRead) || rxFrameNow || rxPar_q))
                       || (errorSum && !errClear);
      end
   end

   // flow control out and bit-rate clock on the chosen pin
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rtsOut          <= 1'b1;
         clkDiv_q        <= 4'h0;
         channelClockOut <= 1'b1;
         channelClockEn  <= 1'b0;
         altClockOut     <= 1'b1;
         altClockEn      <= 1'b0;
      end else begin
         rtsOut          <= (flowSel == SIO_FLOW_RTS) ? !(rxEnable && rxArmed_q && !rxFull) : 1'b1;
         clkDiv_q        <= clkDiv_q + 4'(tick16);
         channelClockOut <= !clkDiv_q[3];
         altClockOut     <= !clkDiv_q[3];
         channelClockEn  <= CHAN == SIO_CH_ALTCLK && !extEff && clkPinSel == SIO_CKP_MAIN;
         altClockEn      <= CHAN == SIO_CH_ALTCLK && !extEff && clkPinSel == SIO_CKP_ALT;
      end
   end

   // checks
   sequence txLeaveIdle;
      txSt_q == SIO_TX_IDLE ##1 txSt_q == SIO_TX_START;
   endsequence
   sequence rxLoadFresh;
      rxLoad && !rxFull && !rxRead;
   endsequence
   sequence rxLoadOver;
      rxLoad && rxFull && !rxRead;
   endsequence

   txStart_cond_a: assert property (txLeaveIdle |-> $past(txEnable) && !$past(txEmpty && !fifoValid)
      && ($past(flowSel) != SIO_FLOW_CTS || !$past(ctsIn))) else $error("tx started without condition");
   rxStart_cond_a: assert property (rxSt_q == SIO_RX_IDLE ##1 rxSt_q == SIO_RX_START
      |-> $past(rxEnable) && !$past(rxIn)) else $error("rx started without start bit");
   rxIrq_fresh_a: assert property (rxLoadFresh |=> rxIrq && rxFull ##1 !rxIrq)
      else $error("receive irq not one pulse");
   overrun_keep_a: assert property (rxLoadOver |=> overrunErr && errorSum && !rxIrq)
      else $error("overrun not flagged");
   framing_flag_a: assert property (rxLoad && rxFrameNow |=> framingErr)
      else $error("framing error lost");
   err_summary_a: assert property ((overrunErr || framingErr || parityErr) |-> errorSum)
      else $error("summary flag missing");
   txIrq_cause_a: assert property (txIrq |-> $past(txIrqCause ? txDone : txLoad))
      else $error("transmit irq at wrong point");
   idle_line_a: assert property (txSt_q == SIO_TX_IDLE && !pinInv ##1 txSt_q == SIO_TX_IDLE
      |-> serialOutPin && (serialOutEn == !$past(openDrain))) else $error("idle line not high");
   first_bit_a: assert property (txSt_q == SIO_TX_START ##1 txSt_q == SIO_TX_DATA
      |-> txLine_q == txShift_q[msbFirst ? lastBit : 4'h0]) else $error("wrong bit order");
   sleep_drop_a: assert property (rxEnd && sleepEff && !rxShift_q[lastBit] |=> !rxIrq && $stable(rxData))
      else $error("sleep accepted char");
   clk_pin_a: assert property ((channelClockEn || altClockEn) |-> CHAN == SIO_CH_ALTCLK && !$past(extEff))
      else $error("clock driven with external source");
endmodule

// [rtl/sio_pkg.sv]
package sio_pkg;
   // prescaler source select codes
   localparam logic [1:0] SIO_SRC_F1    = 2'h0;
   localparam logic [1:0] SIO_SRC_F8    = 2'h1;
   localparam logic [1:0] SIO_SRC_F32   = 2'h2;
   localparam logic [4:0] SIO_F8_MASK   = 5'h07;
   localparam logic [4:0] SIO_F32_MASK  = 5'h1F;
   // frame layout
   localparam logic [3:0] SIO_BASE_LEN  = 4'h7;
   localparam logic [3:0] SIO_CHAR_W    = 4'h9;
   localparam logic [8:0] SIO_FULL_MASK = 9'h1FF;
   localparam logic [1:0] SIO_LEN7      = 2'h0;
   localparam logic [1:0] SIO_LEN9      = 2'h2;
   // oversampling phase points (sixteen ticks per bit)
   localparam logic [3:0] SIO_PH_MID    = 4'h7;
   localparam logic [3:0] SIO_PH_END    = 4'hF;
   // flow control and clock pin select codes
   localparam logic [1:0] SIO_FLOW_CTS  = 2'h1;
   localparam logic [1:0] SIO_FLOW_RTS  = 2'h2;
   localparam logic [1:0] SIO_CKP_MAIN  = 2'h1;
   localparam logic [1:0] SIO_CKP_ALT   = 2'h2;
   // channel numbers owning optional features
   localparam int         SIO_CH_ALTCLK = 1;
   localparam int         SIO_CH_LOGIC  = 2;
   // reset values
   localparam logic       SIO_LINE_IDLE = 1'b1;
   localparam logic       SIO_ARM_RST   = 1'b1;

   typedef enum logic [4:0] {
      SIO_TX_IDLE = 5'h01, SIO_TX_START = 5'h02, SIO_TX_DATA = 5'h04,
      SIO_TX_PAR  = 5'h08, SIO_TX_STOP  = 5'h10
   } sio_txst_t;

   typedef enum logic [4:0] {
      SIO_RX_IDLE = 5'h01, SIO_RX_START = 5'h02, SIO_RX_DATA = 5'h04,
      SIO_RX_PAR  = 5'h08, SIO_RX_STOP  = 5'h10
   } sio_rxst_t;
endpackage

// [rtl/sio_brg.sv]
`timescale 1ns/1ps
// bit-rate generator: prescaler, source mux and n+1 divider, gives the 16x tick
module sio_brg import sio_pkg::*; #(
   parameter int DIV_W = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [1:0]       srcSel,
   input  wire logic             extSel,
   input  wire logic             extClkIn,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick16
);
   generate
      if (DIV_W < 1 || DIV_W > 16) begin : g_chk
         $error("sio_brg: DIV_W out of range");
      end
   endgenerate

   logic [4:0]       pre_q;
   logic             extPrev_q;
   logic [DIV_W-1:0] cnt_q;
   logic             preTick;
   logic             srcTick;

   // free running prescaler; f1 passes every cycle
   always_comb begin
      case (srcSel)
         SIO_SRC_F8:  preTick = (pre_q & SIO_F8_MASK) == SIO_F8_MASK;
         SIO_SRC_F32: preTick = (pre_q & SIO_F32_MASK) == SIO_F32_MASK;
         default:     preTick = 1'b1;
      endcase
   end
   assign srcTick = extSel ? (extClkIn & ~extPrev_q) : preTick;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre_q     <= 5'h00;
         extPrev_q <= 1'b0;
      end else begin
         pre_q     <= pre_q + 5'h01;
         extPrev_q <= extClkIn;
      end
   end

   // reload divider counts n+1 source ticks per output tick
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q  <= '0;
         tick16 <= 1'b0;
      end else begin
         tick16 <= 1'b0;
         if (srcTick) begin
            if (cnt_q == '0) begin
               cnt_q  <= divisor;
               tick16 <= 1'b1;
            end else begin
               cnt_q <= cnt_q - DIV_W'(1);
            end
         end
      end
   end
endmodule

// [rtl/sio_fifo.sv]
`timescale 1ns/1ps
// small valid/ready buffer; flags are registered so ready never depends on the sink
module sio_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
         $error("sio_fifo: DEPTH must be a power of two >= 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic [AW:0]      count_d;
   logic             push;
   logic             pop;

   assign push    = inValid & inReady;
   assign pop     = outValid & outReady;
   assign outData = mem_q[rdPtr_q];
   assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   // pointers and honest full/empty flags
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_q  <= '0;
         rdPtr_q  <= '0;
         count_q  <= '0;
         inReady  <= 1'b1;
         outValid <= 1'b0;
      end else begin
         wrPtr_q  <= wrPtr_q + AW'(push);
         rdPtr_q  <= rdPtr_q + AW'(pop);
         count_q  <= count_d;
         inReady  <= count_d != (AW+1)'(DEPTH);
         outValid <= count_d != '0;
      end
   end
endmodule

// [bench/sio_remote_model.sv]
`timescale 1ns/1ps
// remote transceiver: 8 data bits lsb first, one parity cell, one stop cell
module sio_remote_model #(
   parameter int BIT_CYC = 32
) (
   input  wire logic  sys_clk,
   input  wire logic  lineIn,
   output logic       lineOut,
   output logic [8:0] gotWord,
   output logic       gotStrobe
);
   initial begin
      lineOut = 1'b1;
      gotStrobe = 1'b0;
      gotWord = 9'h000;
   end
   // one frame, then idle high; a low stopBit models a broken stop cell
   task automatic send(input logic [7:0] w, input logic parBit, input logic stopBit);
      logic [11:0] f;
      f = {1'b1, stopBit, parBit, w, 1'b0};
      for (int i = 0; i < 12; i++) begin
         lineOut <= f[i];
         repeat (BIT_CYC) @(posedge sys_clk);
      end
   endtask
   // centre sampling; a low shorter than half a cell is not a start
   always begin
      @(negedge lineIn);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      if (lineIn == 1'b0) begin
         for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk);
            gotWord[i] <= lineIn;
         end
         repeat (BIT_CYC) @(posedge sys_clk);
         gotStrobe <= 1'b1;
         @(posedge sys_clk);
         gotStrobe <= 1'b0;
      end
   end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
// self-checking bench: drivers note expectations, watchers pop them
module tb;
   localparam int BIT_CYC = 32; // divisor 1 on the undivided clock
   logic        sys_clk, resetn, txEnable, rxEnable, msbFirst, txValid, rxRead, errClear, ctsIn, contRecv;
   logic        parityOdd, twoStop, extClkSel, chanClk, dataInv, pinInv, sleepSel, openDrain, txCause;
   logic [1:0]  clkPinSel, flowSel;
   logic [8:0]  txData, rxData, gotWord;
   logic        txReady, txEmpty, rxFull, txIrq, rxIrq, overrunErr, framingErr, parityErr, errorSum;
   logic        serialIn, serialOut, serialOutEn, gotStrobe, rtsOut;
   int          num_errors, check_count, txIrqs;
   logic [10:0] txq[$], rxq[$];
   logic [7:0]  d, r;

   sio_uart #(.CHAN(0)) i_sio_uart (.sys_clk(sys_clk), .resetn(resetn), .txEnable(txEnable),
      .rxEnable(rxEnable), .msbFirst(msbFirst), .charLen(2'h1), .parityEn(1'b1), .parityOdd(parityOdd),
      .twoStop(twoStop), .clkSrcSel(2'h0), .extClkSel(extClkSel), .brgDivisor(8'h01), .flowSel(flowSel),
      .txIrqCause(txCause), .contRecv(contRecv), .clkPinSel(clkPinSel), .dataInvert(dataInv),
      .pinInvert(pinInv), .sleepSel(sleepSel), .openDrain(openDrain), .errClear(errClear),
      .txData(txData), .txValid(txValid), .txReady(txReady), .txEmpty(txEmpty), .rxData(rxData),
      .rxFull(rxFull), .rxRead(rxRead), .txIrq(txIrq), .rxIrq(rxIrq), .overrunErr(overrunErr),
      .framingErr(framingErr), .parityErr(parityErr), .errorSum(errorSum), .serialInPin(serialIn),
      .serialOutPin(serialOut), .serialOutEn(serialOutEn), .ctsIn(ctsIn), .rtsOut(rtsOut),
      .channelClockIn(chanClk), .channelClockOut(), .channelClockEn(), .altClockOut(), .altClockEn());
   sio_remote_model #(.BIT_CYC(BIT_CYC)) i_sio_remote_model (.sys_clk(sys_clk), .lineIn(serialOut),
      .lineOut(serialIn), .gotWord(gotWord), .gotStrobe(gotStrobe));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic wrap_up;
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic compare(input string what, input logic [10:0] exp, input logic [10:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_up;
      num_errors++;
      wrap_up();
   endtask
   // hold the word until the edge that samples txReady high
   task automatic put(input logic [8:0] w);
      int n;
      n = 0;
      txData <= w;
      txValid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (txReady !== 1'b1 && n < 4000);
      if (n >= 4000) give_up();
   endtask
   task automatic settle;
      int n;
      n = 0;
      while ((txq.size() > 0 || rxq.size() > 0) && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 20000) give_up();
      repeat (BIT_CYC) @(posedge sys_clk);
   endtask

   // a result with no note pending compares against all ones
   always @(posedge sys_clk) begin
      if (txIrq === 1'b1) txIrqs++;
      if (gotStrobe === 1'b1) compare("line word", txq.size() > 0 ? txq.pop_front() : 11'h7FF, {2'h0, gotWord});
      if (rxIrq === 1'b1) compare("received", rxq.size() > 0 ? rxq.pop_front() : 11'h7FF,
         {errorSum, parityErr, framingErr, rxData[7:0]});
   end

   initial begin
      void'($urandom(32'h1fe2));
      {resetn, txValid, rxRead, errClear, msbFirst, parityOdd, twoStop, extClkSel, chanClk} = '0;
      {dataInv, pinInv, sleepSel, openDrain, txCause, clkPinSel} = '0;
      {txEnable, rxEnable, ctsIn, contRecv} = 4'hF;
      txData = 9'h000;
      flowSel = 2'h1;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      compare("idle line", 11'h003, {9'h000, serialOutEn, serialOut});
      // clear-to-send held high: buffer fills, nothing leaves
      for (int k = 0; k < 2; k++) begin
         d = 8'($urandom);
         txq.push_back({2'h0, ^d, d});
         put({1'b0, d});
      end
      txValid <= 1'b0;
      repeat (BIT_CYC * 4) @(posedge sys_clk);
      compare("held", 11'h001, {8'h00, txEmpty, txReady, serialOut});
      ctsIn <= 1'b0;
      d = 8'($urandom);
      txq.push_back({2'h0, ^d, d});
      put({1'b0, d});
      txValid <= 1'b0;
      settle();
      // msb first: the lsb-first decoder sees the word reversed
      msbFirst <= 1'b1;
      d = 8'($urandom);
      r = {<<{d}};
      txq.push_back({2'h0, ^d, r});
      put({1'b0, d});
      txValid <= 1'b0;
      settle();
      msbFirst <= 1'b0;
      // good, bad parity, low stop; reading re-arms the receiver
      for (int k = 0; k < 3; k++) begin
         d = 8'($urandom);
         rxq.push_back({k != 0, k == 1, k == 2, d});
         i_sio_remote_model.send(d, ^d ^ (k == 1), k != 2);
         settle();
         rxRead <= 1'b1;
         errClear <= 1'b1;
         @(posedge sys_clk);
         {rxRead, errClear} <= 2'h0;
      end
      // rts mode: armed and empty asks for data; sleep drops a character with msb clear
      flowSel <= 2'h2;
      sleepSel <= 1'b1;
      repeat (2) @(posedge sys_clk);
      compare("rts ready", 11'h000, {10'h000, rtsOut});
      d = 8'($urandom);
      i_sio_remote_model.send({1'b0, d[6:0]}, ^d[6:0], 1'b1);
      sleepSel <= 1'b0;
      // unread buffer, dummy write re-arms, second character overruns
      d = 8'($urandom);
      rxq.push_back({3'h0, d});
      i_sio_remote_model.send(d, ^d, 1'b1);
      txq.push_back({2'h0, ^d, d});
      put({1'b0, d});
      txValid <= 1'b0;
      i_sio_remote_model.send(~d, ^d, 1'b1);
      settle();
      compare("overrun", {3'h6, ~d}, {errorSum, overrunErr, framingErr, rxData[7:0]});
      compare("rts full", 11'h001, {10'h000, rtsOut});
      compare("tx events", 11'h005, 11'(txIrqs));
      wrap_up();
   end
endmodule
